//--- pkg/fsg_pkg.sv
// shared constants and carriers for the frame sync generation block
package fsg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map: avalon word index
   localparam int ADDR_W = 3;
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_GEN = 3'h1;
   localparam logic [2:0] IDX_TXDATA = 3'h2;
   localparam logic [2:0] IDX_STATUS = 3'h3;
   localparam logic [2:0] IDX_SHIFT = 3'h4;

   // field layout of the generator register
   localparam int PERIOD_W = 12;
   localparam int WIDTH_W = 8;
   localparam int GEN_PERIOD_LSB = 0;
   localparam int GEN_WIDTH_LSB = 16;
   localparam logic [31:0] GEN_RESET = 32'h0000_0000;

   // holding register must see this many transmit bit clocks before a frame
   localparam logic [1:0] READY_EDGES = 2'h3;

   // interrupt select code for frame detection
   localparam logic [1:0] INT_SEL_FRAME = 2'h2;

   // synchronised pin inputs, one bit each
   localparam int PIN_GEN_CLK = 0;
   localparam int PIN_TX_CLK = 1;
   localparam int PIN_RX_FS = 2;
   localparam int PIN_TX_FS = 3;
   localparam int PIN_COUNT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // control register, bit 0 is frame_gen_reset_n
   typedef struct packed {
      logic [1:0] tx_interrupt_select;
      logic [1:0] rx_interrupt_select;
      logic tx_clock_direction;
      logic tx_sync_polarity;
      logic tx_sync_direction;
      logic rx_sync_polarity;
      logic rx_sync_direction;
      logic loopback_enable;
      logic clock_resync_enable;
      logic tx_sync_generator_select;
      logic frame_gen_reset_n;
   } fsg_ctrl_s;
   localparam int CTRL_W = $bits(fsg_ctrl_s);
   localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;

   // status register, read only
   typedef struct packed {
      logic tx_frame_sync_internal;
      logic rx_frame_sync_internal;
      logic generated_frame_pulse;
      logic holding_full;
      logic tx_empty_flag;
   } fsg_status_s;
   localparam int STATUS_W = $bits(fsg_status_s);

endpackage : fsg_pkg

//--- verilog/fsg_pin_sync.sv
// three-stage pin synchronisers with agreement filter and rise detect
`timescale 1ns/1ps
module fsg_pin_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous inputs
   input wire logic [WIDTH-1:0] async_in,
   // filtered level and one-cycle rise pulse
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   if (WIDTH < 1) $error("fsg_pin_sync: WIDTH must be at least 1");

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;
      // s1 feeds s2 only; a change counts once s2 and s3 agree
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
         end else begin
            s1_reg <= async_in[i];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= (s2_reg == s3_reg) ? s3_reg : level_reg;
            rise_reg <= s2_reg & s3_reg & ~level_reg;
         end
      end
      assign level[i] = level_reg;
      assign rise[i] = rise_reg;
   end

endmodule : fsg_pin_sync

//--- verilog/fsg_frame_counter.sv
// period and width down counters that make the generated frame pulse
`timescale 1ns/1ps
module fsg_frame_counter #(
   parameter int PERIOD_W = 12,
   parameter int WIDTH_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic tick,
   input wire logic resync_mode,
   input wire logic resync_event,
   input wire logic [PERIOD_W-1:0] period,
   input wire logic [WIDTH_W-1:0] width,
   // frame pulse
   output logic pulse
);

   if (PERIOD_W < 1 || WIDTH_W < 1) $error("fsg_frame_counter: widths must be positive");

   logic [PERIOD_W-1:0] period_reg;
   logic [WIDTH_W-1:0] width_reg;
   logic pulse_reg, pend_reg;
   wire logic start = resync_mode ? (pend_reg | resync_event) : (period_reg == '0);

   ////////////////////////////////////////////////////////////////////////////
   // counters load value+1 by loading value on the start tick itself
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         period_reg <= '0;
         width_reg <= '0;
         pulse_reg <= 1'b0; // [RQ9]
         pend_reg <= 1'b0;
      end else if (tick) begin
         pend_reg <= 1'b0;
         if (start) begin
            period_reg <= period; // [RQ7] [RQ24]
            width_reg <= width; // [RQ8] [RQ24]
            pulse_reg <= 1'b1; // [RQ10]
         end else begin
            period_reg <= period_reg - 1'b1; // [RQ7] [RQ10]
            width_reg <= (width_reg == '0) ? width_reg : width_reg - 1'b1;
            pulse_reg <= pulse_reg & (width_reg != '0); // [RQ8]
         end
      end else begin
         // a resync edge between bit clocks waits for the next one
         pend_reg <= pend_reg | (resync_mode & resync_event); // [RQ11]
      end
   end
   assign pulse = pulse_reg;

endmodule : fsg_frame_counter

//--- verilog/fsg_frame_sync.sv
// frame sync generation and selection with avalon register access
//
// Notes on behaviour
// RQ1 - halted input bit clock is just slow
// RQ2 - far end keeps bit clock lines glitch free
// RQ3 - late holding write flags transmit empty
// RQ4 - far end restarts clock three edges early
// RQ5 - receive and transmit sync chosen independently
// RQ6 - generator runs only when enabled and selected
// RQ7 - twelve bit period counter, value plus one
// RQ8 - eight bit width counter, value plus one
// RQ9 - generated pulse low until generation begins
// RQ10 - period expiry raises pulse, new frame
// RQ11 - resync ignores period, external sync times frames
// RQ12 - software keeps width below element length
// RQ13 - receive sync from pin, polarity adjusted
// RQ14 - generated pulse drives receive sync, pin output
// RQ15 - generated receive sync, pin resyncs generator
// RQ16 - loopback: transmit sync feeds receive sync
// RQ17 - loopback resync: pin only resyncs generator
// RQ18 - transmit sync from pin, polarity adjusted
// RQ19 - generated pulse drives transmit sync and pin
// RQ20 - copy makes one bit clock transmit sync
// RQ21 - copy framing slower with delay one, two
// RQ22 - interrupt select 10b signals frame detection
// RQ23 - detection uses synchronised adjusted sync, even reset
// RQ24 - counters reload each frame, step on bit clock
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fsg_frame_sync #(
   parameter int PERIOD_W = fsg_pkg::PERIOD_W,
   parameter int WIDTH_W = fsg_pkg::WIDTH_W
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // avalon-mm slave, word addressed
   input wire logic [fsg_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // bit clocks from outside this clock domain
   input wire logic GENERATED_BIT_CLOCK,
   input wire logic TX_BIT_CLOCK_IN,
   // receive frame sync pin
   input wire logic RX_FRAME_SYNC_PIN_IN,
   output logic RX_FRAME_SYNC_PIN_OUT,
   output logic RX_FRAME_SYNC_PIN_OE_N,
   // transmit frame sync pin
   input wire logic TX_FRAME_SYNC_PIN_IN,
   output logic TX_FRAME_SYNC_PIN_OUT,
   output logic TX_FRAME_SYNC_PIN_OE_N,
   // events and status
   output logic RX_INTERRUPT,
   output logic TX_INTERRUPT,
   output logic TX_EMPTY_FLAG
);

   if (PERIOD_W != fsg_pkg::PERIOD_W || WIDTH_W != fsg_pkg::WIDTH_W)
      $error("fsg_frame_sync: counter widths are fixed by the register layout");

   ////////////////////////////////////////////////////////////////////////////
   // registers and state

   logic [fsg_pkg::CTRL_W-1:0] ctrl_reg;
   logic [31:0] gen_reg;
   logic [31:0] tx_holding_register_reg;
   logic [31:0] tx_shift_register_reg;
   logic holding_full_reg;
   logic [1:0] ready_count_reg;
   logic tx_empty_reg;
   logic copy_pulse_reg;
   logic rx_int_reg, tx_int_reg;
   logic rx_irq_reg, tx_irq_reg;
   logic rx_out_reg, rx_oe_n_reg, tx_out_reg, tx_oe_n_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;

   fsg_pkg::fsg_ctrl_s ctrl;
   assign ctrl = fsg_pkg::fsg_ctrl_s'(ctrl_reg);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; every outside level passes four flops

   logic [fsg_pkg::PIN_COUNT-1:0] pin_level;
   logic [fsg_pkg::PIN_COUNT-1:0] pin_rise;

   fsg_pin_sync #(
      .WIDTH(fsg_pkg::PIN_COUNT)
   ) u_sync (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .async_in({TX_FRAME_SYNC_PIN_IN, RX_FRAME_SYNC_PIN_IN, TX_BIT_CLOCK_IN, GENERATED_BIT_CLOCK}),
      .level(pin_level),
      .rise(pin_rise)
   );

   // a stopped clock simply gives no edge; no timeout watches it, so a restart
   // continues as one long bit period. glitches seen for two or more core clocks would count as edges.
   wire logic gen_tick = pin_rise[fsg_pkg::PIN_GEN_CLK]; // [RQ1] [RQ2]
   wire logic tx_tick = ctrl.tx_clock_direction ? gen_tick
                                                : pin_rise[fsg_pkg::PIN_TX_CLK]; // [RQ1]

   // pin levels after polarity; polarity 1 means the pin is active low
   wire logic rx_pin_sync = pin_level[fsg_pkg::PIN_RX_FS] ^ ctrl.rx_sync_polarity;
   wire logic tx_pin_sync = pin_level[fsg_pkg::PIN_TX_FS] ^ ctrl.tx_sync_polarity;

   ////////////////////////////////////////////////////////////////////////////
   // frame pulse generator

   logic generated_frame_pulse;
   logic rx_pin_prev_reg;

   wire logic gen_run = ctrl.frame_gen_reset_n & ctrl.tx_sync_generator_select; // [RQ6]
   // only an inactive-to-active change on the receive pin restarts a frame
   wire logic resync_event = rx_pin_sync & ~rx_pin_prev_reg; // [RQ15] [RQ17]

   fsg_frame_counter #(
      .PERIOD_W(PERIOD_W),
      .WIDTH_W(WIDTH_W)
   ) u_counter (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .run(gen_run),
      .tick(gen_tick),
      .resync_mode(ctrl.clock_resync_enable), // [RQ11]
      .resync_event(resync_event),
      .period(gen_reg[fsg_pkg::GEN_PERIOD_LSB +: PERIOD_W]),
      .width(gen_reg[fsg_pkg::GEN_WIDTH_LSB +: WIDTH_W]),
      .pulse(generated_frame_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // transmit frame sync source; copy framing cannot reach the peak packet
   // rate with a data delay of one or two bits, the copy waits on the holding
   // register being ready first

   wire logic tx_copy_mode = ctrl.tx_sync_direction & ~ctrl.tx_sync_generator_select; // [RQ21]
   wire logic tx_sync_sel = !ctrl.tx_sync_direction ? tx_pin_sync // [RQ18] [RQ5]
      : ctrl.tx_sync_generator_select ? generated_frame_pulse // [RQ19]
      : copy_pulse_reg; // [RQ20]
   wire logic tx_out_next = tx_sync_sel ^ ctrl.tx_sync_polarity; // [RQ19] [RQ20]
   wire logic tx_oe_n_next = ~ctrl.tx_sync_direction;

   ////////////////////////////////////////////////////////////////////////////
   // receive frame sync source and pin direction

   wire logic rx_sync_sel = ctrl.loopback_enable ? tx_sync_sel // [RQ16] [RQ17]
      : ctrl.rx_sync_direction ? generated_frame_pulse // [RQ14] [RQ15]
      : rx_pin_sync; // [RQ13] [RQ5]
   // resync keeps the pin an input; loopback with direction 0 leaves it floating
   wire logic rx_oe_n_next = ~(ctrl.rx_sync_direction & ~ctrl.clock_resync_enable);  // [RQ14] [RQ16]
   wire logic rx_out_next = (ctrl.loopback_enable ? tx_sync_sel : generated_frame_pulse)
      ^ ctrl.rx_sync_polarity; // [RQ14] [RQ16]

   ////////////////////////////////////////////////////////////////////////////
   // frame detection; works whatever the generator or data paths are doing

   wire logic rx_sync_rise = rx_sync_sel & ~rx_int_reg; // [RQ23]
   wire logic tx_sync_rise = tx_sync_sel & ~tx_int_reg; // [RQ23]
   wire logic rx_irq_next = (ctrl.rx_interrupt_select == fsg_pkg::INT_SEL_FRAME) & rx_sync_rise; // [RQ22]
   wire logic tx_irq_next = (ctrl.tx_interrupt_select == fsg_pkg::INT_SEL_FRAME) & tx_sync_rise; // [RQ22]

   ////////////////////////////////////////////////////////////////////////////
   // avalon decode; one wait state, the access completes when waitrequest is low

   wire logic bus_req = AVS_READ | AVS_WRITE;
   wire logic bus_done = bus_req & ~wait_reg;
   wire logic wr_done = AVS_WRITE & ~wait_reg;
   wire logic sel_ctrl = (AVS_ADDRESS == fsg_pkg::IDX_CTRL);
   wire logic sel_gen = (AVS_ADDRESS == fsg_pkg::IDX_GEN);
   wire logic sel_txdata = (AVS_ADDRESS == fsg_pkg::IDX_TXDATA);
   wire logic sel_status = (AVS_ADDRESS == fsg_pkg::IDX_STATUS);
   wire logic sel_shift = (AVS_ADDRESS == fsg_pkg::IDX_SHIFT);
   wire logic [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                                {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   wire logic [31:0] ctrl_word = {{(32 - fsg_pkg::CTRL_W){1'b0}}, ctrl_reg};
   wire logic [31:0] ctrl_wr = (ctrl_word & ~be_mask) | (AVS_WRITEDATA & be_mask);
   wire logic [31:0] gen_wr = (gen_reg & ~be_mask) | (AVS_WRITEDATA & be_mask);
   wire logic [31:0] txd_wr = (tx_holding_register_reg & ~be_mask) | (AVS_WRITEDATA & be_mask);
   wire logic holding_write = wr_done & sel_txdata;

   // gen register keeps only its documented fields
   wire logic [31:0] gen_field_mask = {{(32 - fsg_pkg::GEN_WIDTH_LSB - WIDTH_W){1'b0}}, {WIDTH_W{1'b1}},
                                       {(fsg_pkg::GEN_WIDTH_LSB - PERIOD_W){1'b0}}, {PERIOD_W{1'b1}}};

   fsg_pkg::fsg_status_s status;
   assign status.tx_frame_sync_internal = tx_int_reg;
   assign status.rx_frame_sync_internal = rx_int_reg;
   assign status.generated_frame_pulse = generated_frame_pulse;
   assign status.holding_full = holding_full_reg;
   assign status.tx_empty_flag = tx_empty_reg;

   wire logic [31:0] rdata_next = sel_ctrl ? ctrl_word
      : sel_gen ? gen_reg
      : sel_txdata ? tx_holding_register_reg
      : sel_status ? {{(32 - fsg_pkg::STATUS_W){1'b0}}, status}
      : sel_shift ? tx_shift_register_reg
      : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // holding to shift copy and underflow

   // a write needs three transmit bit clocks to settle before it may be used
   wire logic holding_ready = holding_full_reg & (ready_count_reg == fsg_pkg::READY_EDGES); // [RQ3] [RQ4]
   // copy framing copies as soon as data is ready and no pulse is out
   wire logic copy_now_trig = tx_copy_mode & tx_tick & holding_ready & ~copy_pulse_reg;      // [RQ20]
   // other modes copy at the transmit frame start
   wire logic frame_start_tx = ~tx_copy_mode & tx_sync_rise;
   wire logic copy_now_frame = frame_start_tx & holding_ready;
   wire logic underflow = frame_start_tx & ~holding_ready; // [RQ3]
   wire logic copy_now = copy_now_trig | copy_now_frame;

   wire logic [1:0] ready_count_next = holding_write ? 2'h0
      : (tx_tick && ready_count_reg != fsg_pkg::READY_EDGES)
      ? ready_count_reg + 2'h1 : ready_count_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake and read data
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
         rdata_reg <= (AVS_READ & wait_reg) ? rdata_next : rdata_reg;
      end
   end

   // software-written configuration
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         ctrl_reg <= fsg_pkg::CTRL_RESET;
         gen_reg <= fsg_pkg::GEN_RESET;
      end else begin
         ctrl_reg <= (wr_done & sel_ctrl) ? ctrl_wr[fsg_pkg::CTRL_W-1:0] : ctrl_reg;
         gen_reg <= (wr_done & sel_gen) ? (gen_wr & gen_field_mask) : gen_reg;
      end
   end

   // holding and shift registers
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         tx_holding_register_reg <= 32'h0000_0000;
         tx_shift_register_reg <= 32'h0000_0000;
         holding_full_reg <= 1'b0;
         ready_count_reg <= 2'h0;
      end else begin
         tx_holding_register_reg <= holding_write ? txd_wr : tx_holding_register_reg;
         tx_shift_register_reg <= copy_now ? tx_holding_register_reg : tx_shift_register_reg;
         holding_full_reg <= holding_write | (holding_full_reg & ~copy_now);
         ready_count_reg <= ready_count_next; // [RQ3]
      end
   end

   // empty flag: an underflow in the cycle of a holding write still sets it
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         tx_empty_reg <= 1'b0;
      end else begin
         tx_empty_reg <= underflow | (tx_empty_reg & ~holding_write);       // [RQ3]
      end
   end

   // copy-triggered sync lasts exactly one transmit bit clock
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN || !tx_copy_mode) begin
         copy_pulse_reg <= 1'b0;
      end else if (tx_tick) begin
         copy_pulse_reg <= copy_now_trig; // [RQ20]
      end
   end

   // internal syncs, resync edge history and detection pulses
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         rx_int_reg <= 1'b0;
         tx_int_reg <= 1'b0;
         rx_pin_prev_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
         tx_irq_reg <= 1'b0;
      end else begin
         rx_int_reg <= rx_sync_sel;
         tx_int_reg <= tx_sync_sel;
         rx_pin_prev_reg <= rx_pin_sync;
         rx_irq_reg <= rx_irq_next; // [RQ22]
         tx_irq_reg <= tx_irq_next; // [RQ22]
      end
   end

   // pin drivers come straight from flops; enables are active low
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         rx_out_reg <= 1'b0;
         rx_oe_n_reg <= 1'b1;
         tx_out_reg <= 1'b0;
         tx_oe_n_reg <= 1'b1;
      end else begin
         rx_out_reg <= rx_out_next;
         rx_oe_n_reg <= rx_oe_n_next;
         tx_out_reg <= tx_out_next;
         tx_oe_n_reg <= tx_oe_n_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign RX_FRAME_SYNC_PIN_OUT = rx_out_reg;
   assign RX_FRAME_SYNC_PIN_OE_N = rx_oe_n_reg;
   assign TX_FRAME_SYNC_PIN_OUT = tx_out_reg;
   assign TX_FRAME_SYNC_PIN_OE_N = tx_oe_n_reg;
   assign RX_INTERRUPT = rx_irq_reg;
   assign TX_INTERRUPT = tx_irq_reg;
   assign TX_EMPTY_FLAG = tx_empty_reg;

endmodule : fsg_frame_sync

//--- tb/fsg_properties.sv
// port checker for the frame sync block
`timescale 1ns/1ps
module fsg_properties #(
   parameter int PERIOD_W = 12,
   parameter int WIDTH_W = 8
) (
   // clock, reset and bus
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic [2:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic AVS_WAITREQUEST,
   // pins and events
   input wire logic RX_FRAME_SYNC_PIN_OE_N,
   input wire logic TX_FRAME_SYNC_PIN_OE_N,
   input wire logic TX_FRAME_SYNC_PIN_OUT,
   input wire logic RX_INTERRUPT,
   input wire logic TX_INTERRUPT,
   input wire logic TX_EMPTY_FLAG
);
   fsg_pkg::fsg_ctrl_s c_reg, c_next;
   wire wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
   wire wr_txd = wr_ok && AVS_ADDRESS == fsg_pkg::IDX_TXDATA;
   wire gen_off = c_reg.tx_sync_direction && c_reg.tx_sync_generator_select
      && !c_reg.frame_gen_reset_n && !c_reg.tx_sync_polarity;
   // shadow of the control word, byte lanes merged as the slave does
   assign c_next = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[12:8] : c_reg[12:8],
      AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : c_reg[7:0]};
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) c_reg <= '0;
      else if (wr_ok && AVS_ADDRESS == fsg_pkg::IDX_CTRL) c_reg <= c_next;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);
   a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("no answer after one wait");
   a_bus_ack_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("answer held too long");
   a_tx_pin_dir: assert property (TX_FRAME_SYNC_PIN_OE_N == !$past(c_reg.tx_sync_direction))
      else $error("transmit pin direction wrong");
   a_rx_pin_dir: assert property (RX_FRAME_SYNC_PIN_OE_N ==
      !($past(c_reg.rx_sync_direction) && !$past(c_reg.clock_resync_enable)))
      else $error("receive pin direction wrong");
   a_rx_int_pulse: assert property (RX_INTERRUPT |=> !RX_INTERRUPT)
      else $error("receive event too long");
   a_tx_int_sel: assert property (TX_INTERRUPT |-> $past(c_reg.tx_interrupt_select) == 2'h2)
      else $error("transmit event without select");
   a_rx_int_sel: assert property (RX_INTERRUPT |-> $past(c_reg.rx_interrupt_select) == 2'h2)
      else $error("receive event without select");
   a_empty_clear: assert property ($fell(TX_EMPTY_FLAG) |-> $past(wr_txd) || $past(wr_txd, 2))
      else $error("empty flag cleared without write");
   a_gen_idle: assert property (gen_off && $past(gen_off, 2) && $past(gen_off, 4) |-> !TX_FRAME_SYNC_PIN_OUT)
      else $error("pulse while generator off");
   c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
   c_frame: cover property (TX_INTERRUPT);
   c_underflow: cover property ($rose(TX_EMPTY_FLAG));
endmodule : fsg_properties
bind fsg_frame_sync fsg_properties #(.PERIOD_W(PERIOD_W), .WIDTH_W(WIDTH_W)) u_props (.*);

//--- tb/fsg_partner.sv
// far-end serial device: shared bit clock and frame sync pins
`timescale 1ns/1ps
module fsg_partner (
   // bench controls
   input wire logic run,
   input wire logic rx_fs,
   input wire logic tx_fs,
   // device pin drive
   input wire logic rx_oe_n,
   input wire logic rx_out,
   input wire logic tx_oe_n,
   input wire logic tx_out,
   // lines seen by the device
   output logic bit_clk,
   output logic rx_pin,
   output logic tx_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // clean 400 ns clock, stopped low whenever run is low; 10 ns skew keeps it off core edges
   always begin
      bit_clk = 1'b0;
      wait (run);
      #10;
      bit_clk = 1'b1;
      #200;
      bit_clk = 1'b0;
      #190;
   end
   // device drive wins when enabled, else the far end's own level
   assign rx_pin = rx_oe_n ? rx_fs : rx_out;
   assign tx_pin = tx_oe_n ? tx_fs : tx_out;
endmodule : fsg_partner

//--- tb/fsg_frame_sync_tb.sv
// self-checking bench for the frame sync block
`timescale 1ns/1ps
module fsg_frame_sync_tb;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, run = 1'b0, rx_fs = 1'b1, tx_fs = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] wd = 32'h0, rdat, d;
   wire logic [31:0] rdata;
   wire logic wq, bclk, rxp, txp, rxo, txo, rxe, txe, rxi, txi, emp;
   int fails = 0, compares = 0, rxn, txn, p, w, pol, lb;
   bit q[$];
   always #25 clk = ~clk;
   fsg_frame_sync dut (.CORE_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
      .GENERATED_BIT_CLOCK(bclk), .TX_BIT_CLOCK_IN(bclk), .RX_FRAME_SYNC_PIN_IN(rxp),
      .RX_FRAME_SYNC_PIN_OUT(rxo), .RX_FRAME_SYNC_PIN_OE_N(rxe), .TX_FRAME_SYNC_PIN_IN(txp),
      .TX_FRAME_SYNC_PIN_OUT(txo), .TX_FRAME_SYNC_PIN_OE_N(txe), .RX_INTERRUPT(rxi),
      .TX_INTERRUPT(txi), .TX_EMPTY_FLAG(emp));
   fsg_partner far_end (.run(run), .rx_fs(rx_fs), .tx_fs(tx_fs), .rx_oe_n(rxe), .rx_out(rxo),
      .tx_oe_n(txe), .tx_out(txo), .bit_clk(bclk), .rx_pin(rxp), .tx_pin(txp));
   // detection events are single-cycle pulses, so count every one
   always @(posedge clk) begin
      if (rxi === 1'b1) rxn++;
      if (txi === 1'b1) txn++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic print_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w_en, input logic [2:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wd <= v;
      wr <= w_en;
      rd <= !w_en;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) begin
            chk("waitrequest", 0, 1);
            print_verdict;
         end
      end while (wq !== 1'b0);
      rdat = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   // wait for one rise of the bit clock, bounded in case it never comes
   task automatic tick;
      logic was;
      was = 1'b1;
      for (int n = 0; !(bclk === 1'b1 && was === 1'b0); n++) begin
         if (n > 2000) begin
            chk("bit clock", 0, 1);
            print_verdict;
         end
         was = bclk;
         @(posedge clk);
      end
   endtask : tick
   initial begin
      void'($urandom(83421));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, a write with no lanes and an unmapped index
      bus(1'b0, fsg_pkg::IDX_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rdat);
      be <= 4'h0;
      bus(1'b1, fsg_pkg::IDX_CTRL, 32'hffff);
      be <= 4'hf;
      bus(1'b0, fsg_pkg::IDX_CTRL, 32'h0);
      chk("ctrl lanes", 32'h0, rdat);
      bus(1'b1, 3'h7, 32'hffff_ffff);
      bus(1'b0, 3'h7, 32'h0);
      chk("unmapped", 32'h0, rdat);
      bus(1'b0, fsg_pkg::IDX_GEN, 32'h0);
      chk("gen reset", fsg_pkg::GEN_RESET, rdat);
      $display("registers done");
      // pin syncs, receive active low; holding empty so the frame underflows
      bus(1'b1, fsg_pkg::IDX_CTRL, 32'h1420);
      rxn = 0;
      txn = 0;
      rx_fs <= 1'b0;
      tx_fs <= 1'b1;
      repeat (10) @(posedge clk);
      rx_fs <= 1'b1;
      tx_fs <= 1'b0;
      repeat (10) @(posedge clk);
      chk("rx detect", 1, rxn);
      chk("tx detect", 1, txn);
      chk("underflow", 1, emp);
      d = $urandom;
      bus(1'b1, fsg_pkg::IDX_TXDATA, d);
      repeat (2) @(posedge clk);
      chk("empty clear", 0, emp);
      run <= 1'b1;
      repeat (4) tick;
      run <= 1'b0;
      tx_fs <= 1'b1;
      repeat (10) @(posedge clk);
      tx_fs <= 1'b0;
      repeat (10) @(posedge clk);
      chk("serviced", 0, emp);
      bus(1'b0, fsg_pkg::IDX_SHIFT, 32'h0);
      chk("shift copy", d, rdat);
      $display("external sync done");
      // generator selected but not started keeps the pulse low
      bus(1'b1, fsg_pkg::IDX_CTRL, 32'h42);
      run <= 1'b1;
      repeat (2) tick;
      run <= 1'b0;
      chk("gen held", 0, txo);
      p = $urandom_range(6, 1);
      w = $urandom_range(p - 1, 0);
      pol = $urandom_range(1, 0);
      lb = $urandom_range(1, 0);
      bus(1'b1, fsg_pkg::IDX_GEN, w << 16 | p);
      bus(1'b0, fsg_pkg::IDX_GEN, 32'h0);
      chk("gen value", w << 16 | p, rdat);
      bus(1'b1, fsg_pkg::IDX_CTRL, 32'h1453 | pol * 32'ha0 | lb * 8);
      repeat (4) @(posedge clk);
      chk("idle pulse", pol, txo);
      for (int k = 0; k < 2 * (p + 1); k++) q.push_back(k % (p + 1) <= w);
      rxn = 0;
      txn = 0;
      run <= 1'b1;
      // two frames, with the clock halted for a while inside the first
      for (int k = 0; k < 2 * (p + 1); k++) begin
         tick;
         repeat (6) @(posedge clk);
         chk("tx pin", q[0] ^ pol, txo);
         chk("rx pin", q.pop_front() ^ pol, rxo);
         if (k == 1) begin
            run <= 1'b0;
            repeat (60) @(posedge clk);
            run <= 1'b1;
         end
      end
      run <= 1'b0;
      repeat (10) @(posedge clk);
      chk("tx frames", 2, txn);
      chk("rx frames", 2, rxn);
      $display("generator done");
      print_verdict;
   end
endmodule : fsg_frame_sync_tb
